// File: core/ssp_regs.vh
// Constants for the synchronous serial port core
// Assumes inclusion by bare name from every design file
`ifndef SSP_REGS_VH
`define SSP_REGS_VH
// ==========================================================
// Frame formats
`define SSP_FMT_PULSED   2'h0
`define SSP_FMT_SPI      2'h1
`define SSP_FMT_HALF     2'h2
// ==========================================================
// Data path sizes
`define SSP_WORD_W       16
`define SSP_FIFO_DEPTH   4'h8
`define SSP_FIFO_AW      3
`define SSP_CMD_BITS     5'h08
`define SSP_TURN_BITS    5'h01
// ==========================================================
// Interrupt bit positions and levels
`define SSP_INT_TX       0
`define SSP_INT_RX       1
`define SSP_INT_RT       2
`define SSP_INT_ROR      3
`define SSP_SVC_LEVEL    4'h4
// Idle half periods before a receive timeout
`define SSP_TIMEOUT_HALF 7'h40
`endif

// File: core/ssp_fifo.v
// Eight-word first-in first-out store with a registered read word
// Assumes one clock, synchronous active-low reset
`include "ssp_regs.vh"
module ssp_fifo (
    input  wire                   sys_clk,
    input  wire                   rst_n,
    input  wire                   in_valid,
    input  wire [`SSP_WORD_W-1:0] in_data,
    output wire                   in_ready,
    output reg                    out_valid,
    output reg  [`SSP_WORD_W-1:0] out_data,
    input  wire                   out_ready,
    output reg  [3:0]             count
);
    // ======================================================
    // Storage and pointers
    reg [`SSP_WORD_W-1:0] mem [0:7];
    reg [`SSP_FIFO_AW-1:0] wr_ptr;
    reg [`SSP_FIFO_AW-1:0] rd_ptr;
    reg [3:0]              mem_cnt;
    reg                    full;
    wire wr   = in_valid & ~full;
    wire take = out_valid & out_ready;
    wire load = (mem_cnt != 4'h0) & (~out_valid | take);
    wire [3:0] next_count = count + {3'h0, wr} - {3'h0, take};
    assign in_ready = ~full;
    // Memory write port
    always @(posedge sys_clk) begin
        if (wr) begin
            mem[wr_ptr] <= in_data;
        end
    end
    // Pointers, counts and the prefetched head word
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            wr_ptr    <= 3'h0;
            rd_ptr    <= 3'h0;
            mem_cnt   <= 4'h0;
            count     <= 4'h0;
            full      <= 1'b0;
            out_valid <= 1'b0;
            out_data  <= 16'h0000;
        end else begin
            if (wr) begin
                wr_ptr <= wr_ptr + 3'h1;
            end
            if (load) begin
                out_data  <= mem[rd_ptr];
                out_valid <= 1'b1;
                rd_ptr    <= rd_ptr + 3'h1;
            end else if (take) begin
                out_valid <= 1'b0;
            end
            mem_cnt <= mem_cnt + {3'h0, wr} - {3'h0, load};
            count   <= next_count;
            full    <= (next_count == `SSP_FIFO_DEPTH);
        end
    end
endmodule

// File: core/ssp_skid.v
// Two-entry buffer between the receive store and the host read port
// Assumes one clock, synchronous active-low reset
`include "ssp_regs.vh"
module ssp_skid (
    input  wire                   sys_clk,
    input  wire                   rst_n,
    input  wire                   in_valid,
    input  wire [`SSP_WORD_W-1:0] in_data,
    output wire                   in_ready,
    output reg                    out_valid,
    output reg  [`SSP_WORD_W-1:0] out_data,
    input  wire                   out_ready
);
    // ======================================================
    // Head slot and spare slot
    reg                   spare_valid;
    reg [`SSP_WORD_W-1:0] spare_data;
    wire pop  = out_valid & out_ready;
    wire push = in_valid & ~spare_valid;
    assign in_ready = ~spare_valid;
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            out_valid   <= 1'b0;
            out_data    <= 16'h0000;
            spare_valid <= 1'b0;
            spare_data  <= 16'h0000;
        end else if (pop) begin
            if (spare_valid) begin
                out_data    <= spare_data;
                spare_valid <= push;
                spare_data  <= in_data;
            end else begin
                out_valid <= push;
                out_data  <= in_data;
            end
        end else if (push) begin
            if (!out_valid) begin
                out_valid <= 1'b1;
                out_data  <= in_data;
            end else begin
                spare_valid <= 1'b1;
                spare_data  <= in_data;
            end
        end
    end
endmodule

// File: core/ssp_top.v
// Synchronous serial port: master or slave, three frame formats
// Assumes sys_clk at 40 MHz, pins from outside, host ports on sys_clk
//
// Functional notes
// - First divide the system clock by an even prescale of 2 to 254.
// - Further divide by serial_clock_rate plus one, giving 1 to 256.
// - Software keeps system clock 2x (master) or 12x (slave) faster.
// - Host words enter an 8-deep 16-bit transmit store until sent.
// - Received words enter a separate store; host read pops oldest.
// - Four interrupt sources are ORed into one request line.
// - A source reaches the request only while its mask bit is one.
// - Raw and masked source states are both readable.
// - Frames are 4 to 16 bits, most significant bit first.
// - Serial clock idles inactive, toggles only during transfers.
// - Receive timeout when clock idles long with received data waiting.
// - SPI and half-duplex formats hold frame select low per frame.
// - Pulsed format: one-period select pulse; launch rising, latch falling.
// - Half-duplex: send 8-bit command, ignore input, then take reply.
// - Pulsed format idles clock and select low, output released.
// - Pulsed format loads head word with the pulse, MSB next rising.
// - Pulsed format stores the word on the falling edge that latches LSB.
// - SPI clock idles at the level of clock_polarity_bit.
// - clock_phase_bit zero captures on first edge, one on second.
// - SPI master phase zero raises select between words, phase one not.
// - SPI output idles low; clock pad driven only as master.
// - SPI select returns high one period after the last clock edge.
`include "ssp_regs.vh"
module ssp_top (
    input  wire        sys_clk,
    input  wire        rst_n,
    input  wire        enable,
    input  wire        master_mode,
    input  wire [1:0]  frame_format,
    input  wire [3:0]  data_size,
    input  wire        clock_polarity_bit,
    input  wire        clock_phase_bit,
    input  wire        loopback,
    input  wire [7:0]  prescale_divisor,
    input  wire [7:0]  serial_clock_rate,
    input  wire [3:0]  interrupt_mask,
    input  wire [3:0]  int_clear,
    input  wire        tx_wr_valid,
    input  wire [15:0] tx_wr_data,
    output wire        tx_wr_ready,
    output wire        rx_rd_valid,
    output wire [15:0] rx_rd_data,
    input  wire        rx_rd_ready,
    output reg  [3:0]  raw_int_status,
    output reg  [3:0]  masked_int_status,
    output reg         int_req,
    output reg         busy,
    input  wire        serial_clock_pin_in,
    output reg         serial_clock_pin_out,
    output reg         serial_clock_pin_oe,
    input  wire        frame_select_pin_in,
    output reg         frame_select_pin_out,
    output reg         serial_out_pin,
    output reg         serial_out_pin_oe,
    input  wire        serial_in_pin
);
    // ======================================================
    // States
    localparam ST_IDLE = 2'h0;
    localparam ST_LEAD = 2'h1;
    localparam ST_XFER = 2'h2;
    localparam ST_TAIL = 2'h3;

    reg [1:0]  state;
    reg [5:0]  cnt;
    reg [15:0] tx_shift;
    reg [15:0] rx_shift;
    reg        rx_push;
    reg        clk_s1;
    reg        clk_s2;
    reg        clk_s3;
    reg        fs_s1;
    reg        fs_s2;
    reg        din_s1;
    reg        din_s2;
    reg [6:0]  pre_cnt;
    reg [7:0]  scr_cnt;
    reg        half_tick;
    reg [6:0]  to_cnt;

    wire        tx_out_valid;
    wire [15:0] tx_out_data;
    wire [3:0]  tx_count;
    wire        rx_in_ready;
    wire        rx_out_valid;
    wire [15:0] rx_out_data;
    wire        rx_out_ready;
    wire [3:0]  rx_count;

    // ======================================================
    // Pin synchronisers, two stages before any logic
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            clk_s1 <= 1'b0;
            clk_s2 <= 1'b0;
            clk_s3 <= 1'b0;
            fs_s1  <= 1'b1;
            fs_s2  <= 1'b1;
            din_s1 <= 1'b0;
            din_s2 <= 1'b0;
        end else begin
            clk_s1 <= serial_clock_pin_in;
            clk_s2 <= clk_s1;
            clk_s3 <= clk_s2;
            fs_s1  <= frame_select_pin_in;
            fs_s2  <= fs_s1;
            din_s1 <= serial_in_pin;
            din_s2 <= din_s1;
        end
    end

    // ======================================================
    // Frame shape decode
    wire       is_pulsed = (frame_format == `SSP_FMT_PULSED);
    wire       is_spi    = (frame_format == `SSP_FMT_SPI);
    wire       is_half   = (frame_format == `SSP_FMT_HALF);
    wire [4:0] nbits     = {1'b0, data_size} + 5'h01;
    // Half-duplex master frame: command, one turnaround bit, reply
    wire [4:0] total_bits = (is_half && master_mode) ?
                            (nbits + `SSP_CMD_BITS + `SSP_TURN_BITS) : nbits;
    wire [5:0] last_edge  = {total_bits, 1'b0} - 6'h01;
    // Launch on the first edge for pulsed and SPI phase one
    wire       launch_first = is_pulsed | (is_spi & clock_phase_bit);
    wire       sclk_idle    = is_spi & clock_polarity_bit;
    wire       fs_idle      = ~is_pulsed;
    wire [15:0] rx_mask     = ~(16'hFFFF << nbits);
    wire [15:0] tx_aligned  = is_half ? {tx_out_data[7:0], 8'h00} :
                              (tx_out_data << (4'hF - data_size));
    wire [15:0] tx_word     = tx_out_valid ? tx_aligned : 16'h0000;
    // Receive bit source, internal loopback or pin
    wire        rx_bit      = loopback ? serial_out_pin : din_s2;

    // ======================================================
    // Start, continuation and edge events
    wire clk_edge  = clk_s2 ^ clk_s3;
    wire clk_fall  = clk_s3 & ~clk_s2;
    wire start_m   = enable & master_mode & (state == ST_IDLE) & tx_out_valid;
    wire start_s   = enable & ~master_mode & (state == ST_IDLE) &
                     (is_pulsed ? (fs_s2 & clk_fall) : ~fs_s2);
    wire tail_hit  = (state == ST_TAIL) & half_tick & (cnt[1:0] == 2'h1);
    wire cont_ok   = enable & tx_out_valid & (is_pulsed | (is_spi & clock_phase_bit));
    wire do_load   = start_m | start_s | (tail_hit & cont_ok);
    wire tx_pop    = do_load & tx_out_valid;
    wire edge_evt  = master_mode ? half_tick : clk_edge;
    wire is_launch = launch_first ? ~cnt[0] : cnt[0];
    wire run_div   = enable & ~start_m & ~(tail_hit & cont_ok);

    // ======================================================
    // Bit rate divider: prescale halves, then rate field
    wire [6:0] pre_half = (prescale_divisor[7:1] == 7'h00) ? 7'h01 :
                          prescale_divisor[7:1];
    always @(posedge sys_clk) begin
        if (!rst_n || !run_div) begin
            pre_cnt   <= 7'h00;
            scr_cnt   <= 8'h00;
            half_tick <= 1'b0;
        end else begin
            half_tick <= 1'b0;
            if (pre_cnt == pre_half - 7'h01) begin
                pre_cnt <= 7'h00;
                if (scr_cnt == serial_clock_rate) begin
                    scr_cnt   <= 8'h00;
                    half_tick <= 1'b1;
                end else begin
                    scr_cnt <= scr_cnt + 8'h01;
                end
            end else begin
                pre_cnt <= pre_cnt + 7'h01;
            end
        end
    end

    // ======================================================
    // Frame engine
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            state                <= ST_IDLE;
            cnt                  <= 6'h00;
            tx_shift             <= 16'h0000;
            rx_shift             <= 16'h0000;
            rx_push              <= 1'b0;
            serial_clock_pin_out <= 1'b0;
            serial_clock_pin_oe  <= 1'b0;
            frame_select_pin_out <= 1'b0;
            serial_out_pin       <= 1'b0;
            serial_out_pin_oe    <= 1'b0;
            busy                 <= 1'b0;
        end else begin
            rx_push             <= 1'b0;
            serial_clock_pin_oe <= master_mode;
            busy                <= (state != ST_IDLE);
            case (state)
            ST_IDLE: begin
                // Idle levels per format
                serial_clock_pin_out <= sclk_idle;
                frame_select_pin_out <= fs_idle;
                serial_out_pin       <= 1'b0;
                serial_out_pin_oe    <= master_mode & ~is_pulsed;
                cnt                  <= 6'h00;
                if (do_load) begin
                    tx_shift          <= launch_first ? tx_word : {tx_word[14:0], 1'b0};
                    serial_out_pin    <= launch_first ? 1'b0 : tx_word[15];
                    serial_out_pin_oe <= 1'b1;
                    if (start_m) begin
                        // Select asserts; pulsed format raises clock with it
                        frame_select_pin_out <= is_pulsed;
                        serial_clock_pin_out <= is_pulsed ? 1'b1 : sclk_idle;
                        state                <= ST_LEAD;
                    end else begin
                        state <= ST_XFER;
                    end
                end
            end
            ST_LEAD: begin
                // Half period for SPI, full period pulse for pulsed format
                if (half_tick) begin
                    if (is_pulsed && cnt == 6'h00) begin
                        serial_clock_pin_out <= 1'b0;
                        cnt                  <= 6'h01;
                    end else begin
                        frame_select_pin_out <= 1'b0;
                        cnt                  <= 6'h00;
                        state                <= ST_XFER;
                    end
                end
            end
            ST_XFER: begin
                if (!master_mode && !is_pulsed && fs_s2) begin
                    state <= ST_IDLE; // select withdrawn, frame abandoned
                end else if (edge_evt) begin
                    serial_clock_pin_out <= ~serial_clock_pin_out;
                    if (is_launch) begin
                        serial_out_pin <= tx_shift[15];
                        tx_shift       <= {tx_shift[14:0], 1'b0};
                    end else begin
                        rx_shift <= {rx_shift[14:0], rx_bit};
                    end
                    if (cnt == last_edge) begin
                        rx_push <= 1'b1;
                        cnt     <= 6'h00;
                        state   <= master_mode ? ST_TAIL : ST_IDLE;
                    end else begin
                        cnt <= cnt + 6'h01;
                    end
                end
            end
            default: begin
                // Hold select one period after the last clock edge, then release
                if (half_tick) begin
                    cnt <= cnt + 6'h01;
                    if (cnt[1:0] == 2'h1) begin
                        if (cont_ok) begin
                            tx_shift          <= launch_first ? tx_word :
                                                 {tx_word[14:0], 1'b0};
                            serial_out_pin_oe <= 1'b1;
                            cnt               <= 6'h00;
                            if (is_pulsed) begin
                                frame_select_pin_out <= 1'b1;
                                serial_clock_pin_out <= 1'b1;
                                state                <= ST_LEAD;
                            end else begin
                                state <= ST_XFER;
                            end
                        end else begin
                            frame_select_pin_out <= fs_idle;
                            serial_out_pin       <= 1'b0;
                        end
                    end else if (cnt[1:0] == 2'h3) begin
                        state <= ST_IDLE;
                    end
                end
            end
            endcase
        end
    end

    // ======================================================
    // Transmit store
    ssp_fifo u_tx_fifo (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .in_valid  (tx_wr_valid),
        .in_data   (tx_wr_data),
        .in_ready  (tx_wr_ready),
        .out_valid (tx_out_valid),
        .out_data  (tx_out_data),
        .out_ready (tx_pop),
        .count     (tx_count)
    );

    // ======================================================
    // Receive store and host-side buffer
    ssp_fifo u_rx_fifo (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .in_valid  (rx_push),
        .in_data   (rx_shift & rx_mask),
        .in_ready  (rx_in_ready),
        .out_valid (rx_out_valid),
        .out_data  (rx_out_data),
        .out_ready (rx_out_ready),
        .count     (rx_count)
    );

    ssp_skid u_rx_skid (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .in_valid  (rx_out_valid),
        .in_data   (rx_out_data),
        .in_ready  (rx_out_ready),
        .out_valid (rx_rd_valid),
        .out_data  (rx_rd_data),
        .out_ready (rx_rd_ready)
    );

    // ======================================================
    // Receive timeout: idle half periods while data waits
    wire rx_pending  = (rx_count != 4'h0) | rx_rd_valid;
    wire timeout_evt = half_tick & (to_cnt == `SSP_TIMEOUT_HALF - 7'h01);
    always @(posedge sys_clk) begin
        if (!rst_n || state != ST_IDLE || !rx_pending) begin
            to_cnt <= 7'h00;
        end else if (half_tick && to_cnt != `SSP_TIMEOUT_HALF) begin
            to_cnt <= to_cnt + 7'h01;
        end
    end

    // ======================================================
    // Interrupt sources; sticky bits keep a set over a clear
    wire overrun_evt = rx_push & ~rx_in_ready;
    wire [3:0] next_raw;
    assign next_raw[`SSP_INT_TX]  = (tx_count <= `SSP_SVC_LEVEL);
    assign next_raw[`SSP_INT_RX]  = (rx_count >= `SSP_SVC_LEVEL);
    assign next_raw[`SSP_INT_RT]  = timeout_evt |
                                    (raw_int_status[`SSP_INT_RT] & ~int_clear[`SSP_INT_RT]);
    assign next_raw[`SSP_INT_ROR] = overrun_evt |
                                    (raw_int_status[`SSP_INT_ROR] & ~int_clear[`SSP_INT_ROR]);
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            raw_int_status    <= 4'h0;
            masked_int_status <= 4'h0;
            int_req           <= 1'b0;
        end else begin
            raw_int_status    <= next_raw;
            masked_int_status <= next_raw & interrupt_mask;
            int_req           <= |(next_raw & interrupt_mask);
        end
    end
endmodule

// File: testbench/ssp_monitor.sv
// Checker for the serial port top module
// Assumes binding to ssp_top, one clock, synchronous active-low reset
`include "ssp_regs.vh"
module ssp_monitor (
    input logic        sys_clk,
    input logic        rst_n,
    input logic        master_mode,
    input logic [1:0]  frame_format,
    input logic        clock_polarity_bit,
    input logic [3:0]  interrupt_mask,
    input logic        rx_rd_valid,
    input logic [15:0] rx_rd_data,
    input logic        rx_rd_ready,
    input logic [3:0]  masked_int_status,
    input logic        int_req,
    input logic        busy,
    input logic        serial_clock_pin_out,
    input logic        serial_clock_pin_oe,
    input logic        frame_select_pin_out,
    input logic        serial_out_pin,
    input logic        serial_out_pin_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========
    // Edges since reset, so pin idle levels have settled
    logic [1:0] age = 2'h0;
    always @(posedge sys_clk) begin
        age <= !rst_n ? 2'h0 : (age == 2'h3 ? age : age + 2'h1);
    end
    wire ok    = age == 2'h3;
    wire spi_m = master_mode && frame_format == `SSP_FMT_SPI;
    wire tim_m = master_mode && frame_format == `SSP_FMT_PULSED;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // ==========
    // Status and request
    a_mask_gate: assert property ((masked_int_status & ~$past(interrupt_mask)) == 4'h0)
        else $error("masked status shows a masked source");
    a_req_source: assert property (int_req |-> |masked_int_status || |$past(masked_int_status))
        else $error("request without an enabled source");
    a_rx_hold: assert property (rx_rd_valid && !rx_rd_ready |=> rx_rd_valid && $stable(rx_rd_data))
        else $error("read word changed while stalled");
    // ==========
    // Pin idle levels
    a_spi_clk_idle: assert property (
        ok && spi_m && $past(spi_m) && serial_clock_pin_out != $past(clock_polarity_bit)
        |-> ##[0:1] busy) else $error("serial clock off idle level while idle");
    a_spi_sel_idle: assert property (
        ok && spi_m && $past(spi_m) && !frame_select_pin_out |-> ##[0:1] busy)
        else $error("select low while idle");
    a_spi_dout_idle: assert property (
        ok && spi_m && $past(spi_m) && serial_out_pin |-> ##[0:1] busy)
        else $error("serial output high while idle");
    a_pulse_idle: assert property (
        ok && tim_m && $past(tim_m)
        && (frame_select_pin_out || serial_clock_pin_out || serial_out_pin_oe)
        |-> ##[0:1] busy) else $error("pulsed format pins not idle");
    a_oe_master: assert property (ok |-> serial_clock_pin_oe == $past(master_mode))
        else $error("clock pad enable differs from role");
    c_req: cover property (int_req);
    c_pop: cover property (rx_rd_valid && rx_rd_ready);
    c_spi_frame: cover property (spi_m && !frame_select_pin_out);
endmodule

bind ssp_top ssp_monitor u_mon (.sys_clk, .rst_n, .master_mode, .frame_format,
    .clock_polarity_bit, .interrupt_mask, .rx_rd_valid, .rx_rd_data, .rx_rd_ready,
    .masked_int_status, .int_req, .busy, .serial_clock_pin_out, .serial_clock_pin_oe,
    .frame_select_pin_out, .serial_out_pin, .serial_out_pin_oe);

// File: testbench/ssp_slave_model.sv
// Behavioural serial slave on the port's master pins
// Assumes select, clock and data out come from the port as master
module ssp_slave_model (
    input  logic        sclk,
    input  logic        sel_n,
    input  logic        mosi,
    input  logic        cpha,
    input  logic [3:0]  size,
    output logic        miso,
    output logic [15:0] got
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [15:0] REPLY = 16'h3C5A;
    int         idx;
    logic [5:0] edges;
    initial miso = 1'b0;
    // Frame start: phase zero shows the first bit at once
    always @(negedge sel_n) begin
        edges = 6'h00;
        got = 16'h0000;
        idx = cpha ? int'(size) : int'(size) - 1;
        miso = cpha ? ~miso : REPLY[size];
    end
    // Released line shows the inverse of the last bit
    always @(posedge sel_n) miso = ~miso;
    // Capture on odd or even edges by phase, launch on the others
    always @(sclk) if (!sel_n) begin
        edges = edges + 6'h01;
        if (edges[0] == !cpha) got = {got[14:0], mosi};
        else begin
            miso = idx >= 0 ? REPLY[idx] : ~miso;
            idx = idx - 1;
        end
    end
endmodule

// File: testbench/sync_serial_port_tb.sv
// Self-checking bench for the serial port top module
// Assumes the checker is bound in and the slave model sits on the pins
`include "ssp_regs.vh"
module sync_serial_port_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        sys_clk = 1'b0, rst_n = 1'b0, enable = 1'b1, master_mode = 1'b1;
    logic        loopback = 1'b0, clock_polarity_bit = 1'b0, clock_phase_bit = 1'b0;
    logic        tx_wr_valid = 1'b0, rx_rd_ready = 1'b0;
    logic [1:0]  frame_format = `SSP_FMT_SPI;
    logic [3:0]  data_size = 4'h3, interrupt_mask = 4'h0, int_clear = 4'h0;
    logic [15:0] tx_wr_data = 16'h0000;
    wire         tx_wr_ready, rx_rd_valid, int_req, busy, sck, sck_oe, fs, sdo, sdo_oe, sdi;
    wire  [15:0] rx_rd_data, slave_got;
    wire  [3:0]  raw_int_status, masked_int_status;
    wire         sck_line = sck_oe ? sck : 1'b0;
    int          mismatches = 0, checks = 0, cycles = 0, n;
    ssp_top u_dut (.sys_clk, .rst_n, .enable, .master_mode, .frame_format, .data_size,
        .clock_polarity_bit, .clock_phase_bit, .loopback, .prescale_divisor(8'h04),
        .serial_clock_rate(8'h01), .interrupt_mask, .int_clear, .tx_wr_valid, .tx_wr_data,
        .tx_wr_ready, .rx_rd_valid, .rx_rd_data, .rx_rd_ready, .raw_int_status,
        .masked_int_status, .int_req, .busy, .serial_clock_pin_in(sck_line),
        .serial_clock_pin_out(sck), .serial_clock_pin_oe(sck_oe), .frame_select_pin_in(fs),
        .frame_select_pin_out(fs), .serial_out_pin(sdo), .serial_out_pin_oe(sdo_oe),
        .serial_in_pin(sdi));
    ssp_slave_model u_slave (.sclk(sck), .sel_n(fs), .mosi(sdo), .cpha(clock_phase_bit),
        .size(data_size), .miso(sdi), .got(slave_got));
    // ==========
    // Clock and hang guard
    initial forever #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            give_verdict;
        end
    end
    // ==========
    // Helpers
    function automatic logic [15:0] msk(input logic [3:0] s);
        return 16'hFFFF >> (4'hF - s);
    endfunction
    function automatic logic [15:0] wd(input int i);
        return 16'hC003 ^ (16'(i) * 16'h0111);
    endfunction
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task put(input logic [15:0] w);
        #1 tx_wr_valid = 1'b1;
        tx_wr_data = w;
        n = 0;
        do begin @(posedge sys_clk); n++; end while (tx_wr_ready !== 1'b1 && n < 3000);
    endtask
    task get(input logic [15:0] exp);
        #1 rx_rd_ready = 1'b1;
        n = 0;
        do begin @(posedge sys_clk); n++; end while (rx_rd_valid !== 1'b1 && n < 3000);
        chk(rx_rd_data, exp);
        #1 rx_rd_ready = 1'b0;
    endtask
    task idle;
        n = 0;
        repeat (3) @(posedge sys_clk);
        while (busy !== 1'b0 && n < 3000) begin @(posedge sys_clk); n++; end
    endtask
    task until_raw(input int b);
        n = 0;
        while (raw_int_status[b] !== 1'b1 && n < 3000) begin @(posedge sys_clk); n++; end
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ==========
    // Test sequence
    initial begin
        repeat (2) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        // Four clock modes through the slave, shortest and longest frames
        for (int m = 0; m < 4; m++) begin
            #1 {clock_polarity_bit, clock_phase_bit} = 2'(m);
            data_size = m[0] ? 4'hF : 4'h3;
            repeat (2) @(posedge sys_clk);
            put(wd(m));
            #1 tx_wr_valid = 1'b0;
            get(16'h3C5A & msk(data_size));
            chk(slave_got, wd(m) & msk(data_size));
            idle;
        end
        // Pulsed loopback: fill the transmit side, then overrun the receive side
        #1 frame_format = `SSP_FMT_PULSED;
        loopback = 1'b1;
        interrupt_mask = 4'h8;
        for (int i = 0; i < 9; i++) put(wd(i));
        #1 tx_wr_valid = 1'b0;
        repeat (2) @(posedge sys_clk);
        chk(16'(tx_wr_ready), 16'h0000);
        for (int i = 9; i < 11; i++) put(wd(i));
        #1 tx_wr_valid = 1'b0;
        until_raw(3);
        chk(16'(raw_int_status[3]), 16'h0001);
        chk(16'(int_req), 16'h0001);
        chk(16'(masked_int_status), 16'h0008);
        #1 interrupt_mask = 4'h0;
        repeat (2) @(posedge sys_clk);
        chk(16'(int_req), 16'h0000);
        chk(16'(masked_int_status), 16'h0000);
        idle;
        for (int i = 0; i < 10; i++) get(wd(i));
        // Clear sticky flags, then let one received word time out
        #1 int_clear = 4'hC;
        @(posedge sys_clk);
        #1 int_clear = 4'h0;
        repeat (2) @(posedge sys_clk);
        chk(16'(raw_int_status[3:2]), 16'h0000);
        put(wd(11));
        #1 tx_wr_valid = 1'b0;
        until_raw(2);
        chk(16'(raw_int_status[2]), 16'h0001);
        get(wd(11));
        give_verdict;
    end
endmodule
